// >>> core/ssl_card.sv
// Peripheral card end: shifts a byte in and out per eight link clocks while selected.
// Assumes link clock runs only while select is asserted; user logic runs on mclk.
`timescale 1ns/1ps
`include "ssl_consts.svh"
module ssl_card
(
	ssl_link_if.card        link,
	input  wire logic       mclk,
	input  wire logic       reset,
	input  ssl_pkg::ssl_byte_t replyByte,
	output ssl_pkg::ssl_byte_t rxByte,
	output logic            rxStrobe,
	output logic            rxFirst,
	output logic            selected
);
	import ssl_pkg::*;

	// Link-side state, clocked by the master's link clock and cleared by deselect.
	typedef struct packed
	{
		logic [2:0] bitCnt;
		ssl_byte_t  shIn;
		ssl_byte_t  shOut;
		logic       firstDone;
	} ssl_lk_t;
	ssl_lk_t lk_r;
	ssl_lk_t lk_nxt;

	// Hand-off to the mclk side; it survives deselect so the toggle never steps falsely.
	typedef struct packed
	{
		ssl_byte_t  doneByte;
		logic       doneTgl;
		logic       doneFirst;
	} ssl_hand_t;
	ssl_hand_t hd_r;
	ssl_hand_t hd_nxt;

	// Select is asynchronous here; a deasserted select clears the link side at once.
	wire logic linkRst = reset | ~link.selectLink; // see R11

	// Sampling on rising edge, driving on falling edge keeps both sides in step.
	always_comb
	begin
		ssl_byte_t sh;
		sh = {lk_r.shIn[6:0], link.txData}; // see R10
		lk_nxt = lk_r;
		hd_nxt = hd_r;
		lk_nxt.bitCnt = lk_r.bitCnt + 3'h1; // see R6
		lk_nxt.shIn = sh;
		lk_nxt.shOut = {lk_r.shOut[6:0], 1'b0};
		if (lk_r.bitCnt == 3'h7)
		begin
			hd_nxt.doneByte = sh;
			hd_nxt.doneTgl = ~hd_r.doneTgl;
			hd_nxt.doneFirst = ~lk_r.firstDone; // see R4
			lk_nxt.firstDone = 1'b1;
			lk_nxt.shOut = replyByte;
		end
		if (lk_r.bitCnt == 3'h0 && !lk_r.firstDone)
			lk_nxt.shOut = {replyByte[6:0], 1'b0};
	end

	always_ff @(posedge link.linkClk or posedge linkRst)
	begin
		if (linkRst)
		begin
			lk_r.bitCnt <= 3'h0;
			lk_r.shIn <= 8'h00;
			lk_r.shOut <= 8'h00;
			lk_r.firstDone <= 1'b0;
		end
		else
			lk_r <= lk_nxt;
	end

	always_ff @(posedge link.linkClk or posedge reset)
	begin
		if (reset)
			hd_r <= '0;
		else
			hd_r <= hd_nxt;
	end

	// While selected, the receive line moves only on falling edges; before the first one it shows the reply's top bit.
	logic rxOut_r;
	logic rxArmed_r;
	always_ff @(negedge link.linkClk or posedge linkRst)
	begin
		if (linkRst)
		begin
			rxOut_r <= `SSL_RX_IDLE; // see R11
			rxArmed_r <= 1'b0;
		end
		else
		begin
			rxOut_r <= lk_r.shOut[7]; // see R9
			rxArmed_r <= 1'b1;
		end
	end
	assign link.rxData = (rxArmed_r ? rxOut_r : replyByte[7]) & link.selectLink; // see R2

	// System side: the byte toggle and select cross by three-stage synchronisers.
	typedef struct packed
	{
		logic [2:0] tglSync;
		logic [2:0] selSync;
		ssl_byte_t  rxByte;
		logic       rxStrobe;
		logic       rxFirst;
		logic       selected;
	} ssl_cs_t;
	ssl_cs_t cs_r;
	ssl_cs_t cs_nxt;

	always_comb
	begin
		cs_nxt = cs_r;
		cs_nxt.tglSync = {cs_r.tglSync[1:0], hd_r.doneTgl};
		cs_nxt.selSync = {cs_r.selSync[1:0], link.selectLink};
		cs_nxt.rxStrobe = 1'b0;
		if (cs_r.tglSync[2] != cs_r.tglSync[1])
		begin
			cs_nxt.rxByte = hd_r.doneByte;
			cs_nxt.rxFirst = hd_r.doneFirst;
			cs_nxt.rxStrobe = 1'b1;
		end
		if (cs_r.selSync[2] == cs_r.selSync[1])
			cs_nxt.selected = cs_r.selSync[1]; // see R5, R7
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			cs_r <= '0;
		else
			cs_r <= cs_nxt;
	end

	assign rxByte = cs_r.rxByte;
	assign rxStrobe = cs_r.rxStrobe;
	assign rxFirst = cs_r.rxFirst;
	assign selected = cs_r.selected;
endmodule

// >>> core/ssl_consts.svh
// Constants for the selected serial peripheral link: timing counts and address byte layout.
// Assumes both ends include this header by its bare name.
// Overview of operation
// R1: Master alone generates the serial clock.
// R2: Master drives select; card answers only when selected.
// R3: Master asserts select, then shifts bits with clock.
// R4: First command byte carries the target card address.
// R5: Card is selected immediately when select asserts; the selected output rises four mclk edges later.
// R6: Both sides shift data together every clock period.
// R7: Session lasts exactly while select stays asserted.
// R8: Address byte: port 7:6, level1 5:3, level2 2:0.
// R9: Transmit carries commands; receive carries card replies.
// R10: MSB first, eight clocks a byte, partials dropped.
// R11: Deselected card idles output, ignores clock, clears counter.
`ifndef SSL_CONSTS_SVH
`define SSL_CONSTS_SVH
`define SSL_BYTE_BITS      4'h8
`define SSL_ADDR_PORT_HI   7
`define SSL_ADDR_PORT_LO   6
`define SSL_ADDR_L1_HI     5
`define SSL_ADDR_L1_LO     3
`define SSL_ADDR_L2_HI     2
`define SSL_ADDR_L2_LO     0
`define SSL_CLK_HALF_DIV   4'h2
`define SSL_SEL_SETUP      4'h2
`define SSL_RX_IDLE        1'b0
`endif

// >>> core/ssl_link_if.sv
// Link wires between master and peripheral card.
// Assumes the master end drives clock, select and transmit; the card drives receive.
`timescale 1ns/1ps
interface ssl_link_if;
	logic linkClk;
	logic selectLink;
	logic txData;
	logic rxData;
	modport master
	(
		output linkClk,
		output selectLink,
		output txData,
		input  rxData
	);
	modport card
	(
		input  linkClk,
		input  selectLink,
		input  txData,
		output rxData
	);
endinterface

// >>> core/ssl_master.sv
// Master end: divides mclk into the link clock and runs a full-duplex session under select.
// Assumes user holds sessionReq high for the session and offers bytes on txValid/txReady.
`timescale 1ns/1ps
`include "ssl_consts.svh"
module ssl_master
(
	ssl_link_if.master         link,
	input  wire logic          mclk,
	input  wire logic          reset,
	input  wire logic          sessionReq,
	input  ssl_pkg::ssl_byte_t txByte,
	input  wire logic          txValid,
	output logic               txReady,
	output ssl_pkg::ssl_byte_t rxByte,
	output logic               rxStrobe,
	output logic               busy
);
	import ssl_pkg::*;

	typedef struct packed
	{
		ssl_mstate_t st;
		logic [3:0]  div;
		logic [2:0]  bitCnt;
		ssl_byte_t   shOut;
		ssl_byte_t   shIn;
		logic        clk;
		logic        sel;
		logic        tx;
		logic [2:0]  rxSync;
		logic        txReady;
		ssl_byte_t   rxByte;
		logic        rxStrobe;
		logic        busy;
	} ssl_ms_t;
	ssl_ms_t m_r;
	ssl_ms_t m_nxt;

	// The receive pin is synchronised, so it is taken at the falling link edge: the three-flop
	// delay then lands exactly on the bit the card launched at the previous falling edge.
	wire logic rxSample = m_r.rxSync[2];

	always_comb
	begin
		m_nxt = m_r;
		m_nxt.rxSync = {m_r.rxSync[1:0], link.rxData};
		m_nxt.txReady = 1'b0;
		m_nxt.rxStrobe = 1'b0;
		m_nxt.div = m_r.div + 4'h1;
		case (m_r.st)
			SSL_IDLE:
			begin
				m_nxt.clk = 1'b0;
				m_nxt.sel = 1'b0;
				m_nxt.busy = 1'b0;
				m_nxt.div = 4'h0;
				if (sessionReq && txValid)
				begin
					m_nxt.sel = 1'b1; // see R2, R3
					m_nxt.busy = 1'b1;
					m_nxt.shOut = txByte; // see R4, R8
					m_nxt.tx = txByte[7]; // see R10
					m_nxt.txReady = 1'b1;
					m_nxt.bitCnt = 3'h0;
					m_nxt.st = SSL_SETUP;
				end
			end
			SSL_SETUP:
				if (m_r.div == `SSL_SEL_SETUP)
				begin
					m_nxt.div = 4'h0;
					m_nxt.st = SSL_SHIFT;
				end
			SSL_SHIFT:
				if (m_r.div == `SSL_CLK_HALF_DIV)
				begin
					m_nxt.div = 4'h0;
					m_nxt.clk = ~m_r.clk; // see R1
					if (m_r.clk)
					begin
						m_nxt.shIn = {m_r.shIn[6:0], rxSample}; // see R6, R9
						m_nxt.bitCnt = m_r.bitCnt + 3'h1;
						m_nxt.shOut = {m_r.shOut[6:0], 1'b0};
						m_nxt.tx = m_r.shOut[6];
						if (m_r.bitCnt == 3'h7)
						begin
							m_nxt.rxByte = {m_r.shIn[6:0], rxSample};
							m_nxt.rxStrobe = 1'b1;
							if (sessionReq && txValid)
							begin
								m_nxt.shOut = txByte;
								m_nxt.tx = txByte[7];
								m_nxt.txReady = 1'b1;
							end
							else
								m_nxt.st = SSL_HOLD;
						end
					end
				end
			SSL_HOLD:
			begin
				m_nxt.div = 4'h0;
				if (!sessionReq)
				begin
					m_nxt.sel = 1'b0; // see R7
					m_nxt.tx = 1'b0;
					m_nxt.st = SSL_IDLE;
				end
				else if (txValid)
				begin
					m_nxt.shOut = txByte;
					m_nxt.tx = txByte[7];
					m_nxt.txReady = 1'b1;
					m_nxt.st = SSL_SHIFT;
				end
			end
			default:
				m_nxt.st = SSL_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			m_r <= '0;
			m_r.st <= SSL_IDLE;
		end
		else
			m_r <= m_nxt;
	end

	assign link.linkClk = m_r.clk;
	assign link.selectLink = m_r.sel;
	assign link.txData = m_r.tx;
	assign txReady = m_r.txReady;
	assign rxByte = m_r.rxByte;
	assign rxStrobe = m_r.rxStrobe;
	assign busy = m_r.busy;
endmodule

// >>> core/ssl_pkg.sv
// Types shared by both ends of the selected serial peripheral link.
// Assumes ssl_consts.svh is on the include path.
package ssl_pkg;
	typedef logic [7:0] ssl_byte_t;
	typedef enum logic [3:0]
	{
		SSL_IDLE  = 4'b0001,
		SSL_SETUP = 4'b0010,
		SSL_SHIFT = 4'b0100,
		SSL_HOLD  = 4'b1000
	} ssl_mstate_t;
endpackage

// >>> verification/selected_serial_peripheral_link_tb.sv
// Bench joining master and card over one link, with a queue model of the bytes.
// Assumes reply bytes stay fixed for a whole session.
`timescale 1ns/1ps
module selected_serial_peripheral_link_tb;
	import ssl_pkg::*;
	logic      mclk = 1'b0;
	logic      reset = 1'b1;
	logic      sessionReq = 1'b0;
	logic      txValid = 1'b0;
	ssl_byte_t txByte = 8'h00;
	ssl_byte_t replyByte = 8'h00;
	logic      txReady, mStrobe, busy, cStrobe, rxFirst, selected;
	ssl_byte_t mByte, cByte;
	int        error_cnt = 0;
	int        tests_run = 0;
	int        cycles = 0;
	int        mCnt, cCnt, n;
	integer    seed = 32'h29df_1d74;
	ssl_byte_t sent[$];
	ssl_link_if i_ssl_link_if ();
	ssl_master i_ssl_master (.link(i_ssl_link_if.master), .mclk(mclk), .reset(reset),
		.sessionReq(sessionReq), .txByte(txByte), .txValid(txValid), .txReady(txReady),
		.rxByte(mByte), .rxStrobe(mStrobe), .busy(busy));
	ssl_card i_ssl_card (.link(i_ssl_link_if.card), .mclk(mclk), .reset(reset), .replyByte(replyByte),
		.rxByte(cByte), .rxStrobe(cStrobe), .rxFirst(rxFirst), .selected(selected));
	ssl_link_assertions i_ssl_link_assertions (.mclk(mclk), .reset(reset), .linkClk(i_ssl_link_if.linkClk),
		.selectLink(i_ssl_link_if.selectLink), .txData(i_ssl_link_if.txData), .rxData(i_ssl_link_if.rxData));
	always #5 mclk = ~mclk;
	task check(string name, logic [7:0] exp, logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task results();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Strobes are registers, so they are sampled mid-cycle where they have settled.
	always @(negedge mclk)
	begin
		cycles++;
		if (cycles > 20000)
		begin
			error_cnt++;
			results();
		end
		if (cStrobe === 1'b1)
		begin
			check("card byte", sent[cCnt], cByte);
			check("address flag", {7'h00, cCnt == 0}, {7'h00, rxFirst});
			cCnt++;
		end
		if (mStrobe === 1'b1)
		begin
			check("master byte", replyByte, mByte);
			mCnt++;
		end
	end
	initial
	begin
		repeat (3) @(posedge mclk);
		#1 reset = 1'b0;
		repeat (2) @(posedge mclk);
		for (int s = 0; s < 6; s++)
		begin
			n = 1 + ($random(seed) & 3);
			sent.delete();
			cCnt = 0;
			mCnt = 0;
			for (int i = 0; i < n; i++)
				sent.push_back($random(seed));
			@(posedge mclk);
			#1 replyByte = $random(seed);
			sessionReq = 1'b1;
			txValid = 1'b1;
			txByte = sent[0];
			for (int i = 0; i < n; i++)
			begin
				do @(negedge mclk); while (txReady !== 1'b1);
				@(posedge mclk);
				#1 txValid = (i + 1 < n);
				txByte = (i + 1 < n) ? sent[i + 1] : 8'h00;
			end
			while (mCnt < n || cCnt < n)
				@(negedge mclk);
			check("busy open", 8'h01, {7'h00, busy});
			check("selected open", 8'h01, {7'h00, selected});
			@(posedge mclk);
			#1 sessionReq = 1'b0;
			repeat (20) @(posedge mclk);
			check("bytes at card", 8'(n), 8'(cCnt));
			check("busy", 8'h00, {7'h00, busy});
			check("selected", 8'h00, {7'h00, selected});
		end
		results();
	end
endmodule

// >>> verification/ssl_link_assertions.sv
// Checker for the link wires between master and card.
// Assumes every link wire except receive is a register sampled cleanly on mclk.
`timescale 1ns/1ps
module ssl_link_assertions
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic linkClk,
	input wire logic selectLink,
	input wire logic txData,
	input wire logic rxData
);
	logic [2:0] edgeCnt_r;
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset || !selectLink)
			edgeCnt_r <= 3'h0;
		else if ($rose(linkClk))
			edgeCnt_r <= edgeCnt_r + 3'h1;
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	property p_rxIdle;
		!selectLink |-> rxData == 1'b0;
	endproperty
	property p_clkIdle;
		!selectLink |-> !linkClk;
	endproperty
	property p_setup;
		$rose(selectLink) |-> !linkClk [*3];
	endproperty
	property p_half;
		$rose(linkClk) |-> linkClk [*3] ##1 !linkClk;
	endproperty
	property p_txEdge;
		$changed(txData) && selectLink && $past(selectLink) |-> $fell(linkClk);
	endproperty
	property p_rxEdge;
		$changed(rxData) && selectLink && $past(selectLink) |-> !linkClk;
	endproperty
	property p_whole;
		$fell(selectLink) |-> $past(edgeCnt_r) == 3'h0;
	endproperty
	property p_selHold;
		selectLink && linkClk |=> selectLink;
	endproperty
	a_rxIdle: assert property (p_rxIdle) else $error("rxData busy while deselected");
	a_clkIdle: assert property (p_clkIdle) else $error("link clock runs outside a session");
	a_setup: assert property (p_setup) else $error("clock too soon after select");
	a_half: assert property (p_half) else $error("link clock half period wrong");
	a_txEdge: assert property (p_txEdge) else $error("txData moved off falling edge");
	a_rxEdge: assert property (p_rxEdge) else $error("rxData moved while clock high");
	a_whole: assert property (p_whole) else $error("session ended mid byte");
	a_selHold: assert property (p_selHold) else $error("select dropped while clock high");
	c_start: cover property ($rose(selectLink));
	c_end: cover property ($fell(selectLink));
	c_byte: cover property ($rose(linkClk) && edgeCnt_r == 3'h7);
endmodule
